// ### pkg/mpd_defines.vh
// constants for the multiply, control and i/o decode block
`ifndef MPD_DEFINES_VH
`define MPD_DEFINES_VH
// upper-byte opcodes
`define MPD_OP_LOAD_MULT      8'h6a
`define MPD_OP_LOAD_MULT_ACC  8'h6c
`define MPD_OP_LOAD_ACC_MOVE  8'h6b
`define MPD_OP_MULT_MEM       8'h6d
`define MPD_OP_SHIFT_UP       8'h69
`define MPD_OP_PROG_TO_DATA   8'h67
`define MPD_OP_DATA_TO_PROG   8'h7d
`define MPD_OP_STATUS_RESTORE 8'h7b
`define MPD_OP_STATUS_SAVE    8'h7c
`define MPD_OP_GROUP_7F       8'h7f
// low-byte codes under the 7f group
`define MPD_LO_NOP            8'h80
`define MPD_LO_INT_DISABLE    8'h81
`define MPD_LO_INT_ENABLE     8'h82
`define MPD_LO_SAT_OFF        8'h8a
`define MPD_LO_SAT_ON         8'h8b
`define MPD_LO_PUSH           8'h9c
`define MPD_LO_POP            8'h9d
`define MPD_LO_PROD_TO_ACC    8'h8e
`define MPD_LO_ADD_PROD       8'h8f
`define MPD_LO_SUB_PROD       8'h90
// prefixes
`define MPD_PFX_MULT_CONST    3'h4
`define MPD_PFX_PORT_IN       5'h08
`define MPD_PFX_PORT_OUT      5'h09
// field positions
`define MPD_MODE_BIT          7
`define MPD_AUX_SEL_BIT       0
`define MPD_SAT_BIT           1
`define MPD_INT_OFF_BIT       2
// reset values
`define MPD_RST_STATUS        16'h0004
// cycle counts
`define MPD_CYC_PORT          2
`define MPD_CYC_STACK         2
`define MPD_CYC_TABLE         3
`endif

// ### core/mpd_fifo.v
// parameterised fifo holding instruction words ahead of the decoder
`timescale 1ns/1ps
module mpd_fifo #(
   parameter WIDTH = 16,
   parameter DEPTH = 32,
   parameter AW    = 5
)(
   // clock and reset
   input  wire             i_mclk,
   input  wire             i_rst,
   // fill side
   input  wire             i_in_valid,
   output wire             o_in_ready,
   input  wire [WIDTH-1:0] i_in_data,
   // drain side
   output wire             o_out_valid,
   input  wire             i_out_ready,
   output wire [WIDTH-1:0] o_out_data
);
   reg [WIDTH-1:0] mem [0:DEPTH-1]; // word storage
   reg [AW-1:0]    wr_ptr;          // next write slot
   reg [AW-1:0]    rd_ptr;          // next read slot
   reg [AW:0]      count;           // words held
   wire            do_wr;
   wire            do_rd;

   assign o_in_ready  = (count != DEPTH[AW:0]);
   assign o_out_valid = (count != {(AW+1){1'b0}});
   assign o_out_data  = mem[rd_ptr];
   assign do_wr       = i_in_valid & o_in_ready;
   assign do_rd       = o_out_valid & i_out_ready;

   ////////////////////////////////////////////////////////////////////////
   // storage write, no reset needed on data
   always @(posedge i_mclk)
   begin
      if (do_wr)
         mem[wr_ptr] <= i_in_data;
   end

   // pointers and occupancy
   always @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         count  <= {(AW+1){1'b0}};
      end
      else
      begin
         if (do_wr)
            wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
         if (do_rd)
            rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
         if (do_wr & ~do_rd)
            count <= count + 1'b1;
         else if (do_rd & ~do_wr)
            count <= count - 1'b1;
      end
   end
endmodule // mpd_fifo

// ### core/mpd_stack.v
// four-level return stack used by push and pop
`timescale 1ns/1ps
module mpd_stack #(
   parameter WIDTH  = 12,
   parameter LEVELS = 4
)(
   // clock and reset
   input  wire             i_mclk,
   input  wire             i_rst,
   // operations
   input  wire             i_push,
   input  wire             i_pop,
   input  wire [WIDTH-1:0] i_data,
   output wire [WIDTH-1:0] o_top
);
   reg [WIDTH-1:0] lvl [0:LEVELS-1]; // level 0 is the top
   genvar g;

   assign o_top = lvl[0];

   ////////////////////////////////////////////////////////////////////////
   // each level shifts down on push, up on pop; bottom repeats on pop
   generate
      for (g = 0; g < LEVELS; g = g + 1)
      begin : g_lvl
         always @(posedge i_mclk)
         begin
            if (i_rst)
               lvl[g] <= {WIDTH{1'b0}};
            else if (i_push)
               lvl[g] <= (g == 0) ? i_data : lvl[(g == 0) ? 0 : g-1];
            else if (i_pop)
               lvl[g] <= lvl[(g == LEVELS-1) ? g : g+1];
         end
      end
   endgenerate
endmodule // mpd_stack

// ### core/mpd_core.v
// decode and execute of the multiply, control and i/o instruction groups
// Behaviour
// RULE_01 - add product to accumulator, one cycle
// RULE_02 - load multiplicand and add product, one cycle
// RULE_03 - load, accumulate and shift word up
// RULE_04 - multiply multiplicand by memory word into product
// RULE_05 - prefix 100 multiplies constant into product
// RULE_06 - product replaces accumulator in one cycle
// RULE_07 - subtract product from accumulator, one cycle
// RULE_08 - pop stack top into accumulator, two cycles
// RULE_09 - push accumulator onto stack, two cycles
// RULE_10 - copy data word to next address
// RULE_11 - port in/out, two cycles, three-bit port
// RULE_12 - program to data copy, three cycles
// RULE_13 - data to program copy, three cycles
// RULE_14 - mode bit selects indirect via aux register
// RULE_15 - direct address is page bit plus seven
// RULE_16 - port number on low three address lines
// RULE_17 - status bits set, cleared, saved, restored
// RULE_18 - multicycle instructions stall the next fetch
`timescale 1ns/1ps
`include "mpd_defines.vh"
module mpd_core #(
   parameter FIFO_DEPTH = 32,
   parameter FIFO_AW    = 5
)(
   // clock and reset
   input  wire        i_mclk,
   input  wire        i_rst,
   // instruction stream in
   input  wire        i_instr_valid,
   output wire        o_instr_ready,
   input  wire [15:0] i_instr,
   // machine state from the rest of the core
   input  wire [31:0] i_acc,
   input  wire [7:0]  i_aux0,
   input  wire [7:0]  i_aux1,
   input  wire        i_data_page,
   input  wire [11:0] i_tbl_addr,
   // data memory, read is combinational, write takes effect at the edge
   output reg  [7:0]  o_dmem_addr,
   input  wire [15:0] i_dmem_rdata,
   output reg         o_dmem_we,
   output reg  [7:0]  o_dmem_waddr,
   output reg  [15:0] o_dmem_wdata,
   // program memory table access
   output reg  [11:0] o_pmem_addr,
   output reg         o_pmem_re,
   input  wire [15:0] i_pmem_rdata,
   output reg         o_pmem_we,
   output reg  [15:0] o_pmem_wdata,
   // port bus
   output reg  [2:0]  o_port_addr,
   output reg         o_port_re,
   output reg         o_port_we,
   output reg  [15:0] o_port_wdata,
   input  wire [15:0] i_port_rdata,
   // results
   output reg         o_acc_we,
   output reg  [31:0] o_acc_wdata,
   output reg  [15:0] o_mult,
   output reg  [31:0] o_prod,
   output reg  [15:0] o_status,
   output wire        o_int_off,
   output wire        o_sat_on,
   output wire [11:0] o_stack_top
);
   ////////////////////////////////////////////////////////////////////////
   // states, one-hot
   localparam [3:0] ST_IDLE = 4'h1; // take a new word
   localparam [3:0] ST_W1   = 4'h2; // second cycle of a multicycle op
   localparam [3:0] ST_W2   = 4'h4; // third cycle of a table op
   localparam [3:0] ST_EXEC = 4'h8; // unused code guard

   reg  [3:0]  state;         // sequencer state
   reg  [3:0]  next_state;
   reg  [15:0] op;            // held instruction of a multicycle op
   reg  [7:0]  op_addr;       // held operand address

   wire        f_valid;       // fifo has a word
   wire [15:0] f_word;        // fifo head
   reg         f_take;        // pop the fifo head
   wire [15:0] cur;           // word being decoded this cycle
   wire [7:0]  opa;           // effective operand address
   wire [7:0]  hi;
   wire [7:0]  lo;

   reg         stk_push;
   reg         stk_pop;
   wire [11:0] stk_top;

   // the fifo decouples fetch from execution so a stall only backs up the fetch
   mpd_fifo #(
      .WIDTH (16),
      .DEPTH (FIFO_DEPTH),
      .AW    (FIFO_AW)
   ) u_fifo (
      .i_mclk      (i_mclk),
      .i_rst       (i_rst),
      .i_in_valid  (i_instr_valid),
      .o_in_ready  (o_instr_ready),
      .i_in_data   (i_instr),
      .o_out_valid (f_valid),
      .i_out_ready (f_take),
      .o_out_data  (f_word)
   );

   // return stack, twelve bits wide like the program counter
   mpd_stack #(
      .WIDTH  (12),
      .LEVELS (4)
   ) u_stack (
      .i_mclk (i_mclk),
      .i_rst  (i_rst),
      .i_push (stk_push),
      .i_pop  (stk_pop),
      .i_data (i_acc[11:0]),
      .o_top  (stk_top)
   );

   assign o_stack_top = stk_top;
   assign o_int_off   = o_status[`MPD_INT_OFF_BIT];
   assign o_sat_on    = o_status[`MPD_SAT_BIT];

   ////////////////////////////////////////////////////////////////////////
   // address generation for the word at the fifo head
   assign cur = f_word;
   assign hi  = cur[15:8];
   assign lo  = cur[7:0];
   // indirect takes the low byte of the selected aux register
   assign opa = cur[`MPD_MODE_BIT] ?
                (o_status[`MPD_AUX_SEL_BIT] ? i_aux1 : i_aux0) : // see RULE_14
                {i_data_page, cur[6:0]};                       // see RULE_15

   ////////////////////////////////////////////////////////////////////////
   // combinational decode and sequencing
   always @*
   begin
      next_state   = state;
      f_take       = 1'b0;
      stk_push     = 1'b0;
      stk_pop      = 1'b0;

      o_dmem_addr  = opa;
      o_dmem_we    = 1'b0;
      o_dmem_waddr = opa + 8'h01;
      o_dmem_wdata = i_dmem_rdata;

      o_pmem_addr  = i_tbl_addr;
      o_pmem_re    = 1'b0;
      o_pmem_we    = 1'b0;
      o_pmem_wdata = i_dmem_rdata;

      o_port_addr  = cur[10:8];
      o_port_re    = 1'b0;
      o_port_we    = 1'b0;
      o_port_wdata = i_dmem_rdata;

      // one branch per sequencer state
      case (state)
         ST_IDLE:
         begin
            if (f_valid)
            begin
               if (hi[7:5] == `MPD_PFX_MULT_CONST)
                  f_take = 1'b1;
               else if (hi[7:3] == `MPD_PFX_PORT_IN || hi[7:3] == `MPD_PFX_PORT_OUT)
                  next_state = ST_W1;                       // see RULE_11
               else if (hi == `MPD_OP_PROG_TO_DATA || hi == `MPD_OP_DATA_TO_PROG)
                  next_state = ST_W1;                       // see RULE_12
               else if (hi == `MPD_OP_GROUP_7F &&
                        (lo == `MPD_LO_PUSH || lo == `MPD_LO_POP))
                  next_state = ST_W1;                       // see RULE_09
               else
               begin
                  f_take = 1'b1;

                  // shifts write the word to the next higher address
                  if (hi == `MPD_OP_SHIFT_UP || hi == `MPD_OP_LOAD_ACC_MOVE)
                     o_dmem_we = 1'b1;                      // see RULE_10

                  // status save writes the status word
                  if (hi == `MPD_OP_STATUS_SAVE)
                  begin
                     o_dmem_we    = 1'b1;                   // see RULE_17
                     o_dmem_waddr = opa;
                     o_dmem_wdata = o_status;
                  end
               end
            end
         end

         ST_W1:
         begin
            // operand address held from the first cycle
            o_dmem_addr  = op_addr;
            o_dmem_waddr = op_addr;
            o_port_addr  = op[10:8];                        // see RULE_16

            if (op[15:11] == `MPD_PFX_PORT_IN)
            begin
               o_port_re    = 1'b1;
               o_dmem_we    = 1'b1;
               o_dmem_wdata = i_port_rdata;                 // see RULE_11
               next_state   = ST_IDLE;
               f_take       = 1'b1;
            end
            else if (op[15:11] == `MPD_PFX_PORT_OUT)
            begin
               o_port_we  = 1'b1;                           // see RULE_11
               next_state = ST_IDLE;
               f_take     = 1'b1;
            end
            else if (op[15:8] == `MPD_OP_GROUP_7F)
            begin
               stk_push   = (op[7:0] == `MPD_LO_PUSH);      // see RULE_09
               stk_pop    = (op[7:0] == `MPD_LO_POP);       // see RULE_08
               next_state = ST_IDLE;
               f_take     = 1'b1;                           // see RULE_18
            end
            else
            begin
               // table ops: program read strobe in the second cycle, program write strobe in the third
               o_pmem_re  = (op[15:8] == `MPD_OP_PROG_TO_DATA);
               next_state = ST_W2;
            end
         end

         ST_W2:
         begin
            o_dmem_addr  = op_addr;
            o_dmem_waddr = op_addr;

            if (op[15:8] == `MPD_OP_PROG_TO_DATA)
            begin
               o_dmem_we    = 1'b1;
               o_dmem_wdata = i_pmem_rdata;                 // see RULE_12
            end
            else
               o_pmem_we = 1'b1;                            // see RULE_13
            next_state = ST_IDLE;
            f_take     = 1'b1;                              // see RULE_18
         end

         default:
            next_state = ST_IDLE;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // sequencer and held operand
   always @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         state   <= ST_IDLE;
         op      <= 16'h0000;
         op_addr <= 8'h00;
      end
      else
      begin
         state <= next_state;

         if (state == ST_IDLE)
         begin
            op      <= cur;
            op_addr <= opa;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // multiplier, product, accumulator write and status
   always @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         o_mult      <= 16'h0000;
         o_prod      <= 32'h00000000;
         o_acc_we    <= 1'b0;
         o_acc_wdata <= 32'h00000000;
         o_status    <= `MPD_RST_STATUS;
      end
      else
      begin
         o_acc_we <= 1'b0;
         if (state == ST_IDLE && f_valid)
         begin
            // constant multiply: thirteen-bit signed constant
            if (hi[7:5] == `MPD_PFX_MULT_CONST)
               o_prod <= $signed(o_mult) * $signed({{3{cur[12]}}, cur[12:0]}); // see RULE_05
            else if (hi == `MPD_OP_MULT_MEM)
               o_prod <= $signed(o_mult) * $signed(i_dmem_rdata);  // see RULE_04

            if (hi == `MPD_OP_LOAD_MULT || hi == `MPD_OP_LOAD_MULT_ACC ||
                hi == `MPD_OP_LOAD_ACC_MOVE)
               o_mult <= i_dmem_rdata;                             // see RULE_02

            if (hi == `MPD_OP_LOAD_MULT_ACC || hi == `MPD_OP_LOAD_ACC_MOVE ||
                (hi == `MPD_OP_GROUP_7F && lo == `MPD_LO_ADD_PROD))
            begin
               o_acc_we    <= 1'b1;
               o_acc_wdata <= i_acc + o_prod;                      // see RULE_01
            end

            if (hi == `MPD_OP_LOAD_ACC_MOVE)
               o_acc_we <= 1'b1;                                   // see RULE_03

            if (hi == `MPD_OP_GROUP_7F && lo == `MPD_LO_PROD_TO_ACC)
            begin
               o_acc_we    <= 1'b1;
               o_acc_wdata <= o_prod;                              // see RULE_06
            end

            if (hi == `MPD_OP_GROUP_7F && lo == `MPD_LO_SUB_PROD)
            begin
               o_acc_we    <= 1'b1;
               o_acc_wdata <= i_acc - o_prod;                      // see RULE_07
            end

            // status bit updates
            if (hi == `MPD_OP_GROUP_7F && lo == `MPD_LO_INT_DISABLE)
               o_status[`MPD_INT_OFF_BIT] <= 1'b1;                 // see RULE_17

            if (hi == `MPD_OP_GROUP_7F && lo == `MPD_LO_INT_ENABLE)
               o_status[`MPD_INT_OFF_BIT] <= 1'b0;

            if (hi == `MPD_OP_GROUP_7F && lo == `MPD_LO_SAT_ON)
               o_status[`MPD_SAT_BIT] <= 1'b1;

            if (hi == `MPD_OP_GROUP_7F && lo == `MPD_LO_SAT_OFF)
               o_status[`MPD_SAT_BIT] <= 1'b0;

            if (hi == `MPD_OP_STATUS_RESTORE)
               o_status <= {13'h0000, i_dmem_rdata[2:0]};          // see RULE_17
         end

         // pop lands in the accumulator at the end of the second cycle
         if (state == ST_W1 && op[15:8] == `MPD_OP_GROUP_7F && op[7:0] == `MPD_LO_POP)
         begin
            o_acc_we    <= 1'b1;
            o_acc_wdata <= {20'h00000, stk_top};                   // see RULE_08
         end
      end
   end
endmodule // mpd_core

// ### sim/mpd_core_checker.sv
// concurrent checks on the decode block's ports
`timescale 1ns/1ps
module mpd_core_checker #(
   parameter FIFO_DEPTH = 32,
   parameter FIFO_AW    = 5
)(
   // clock and reset
   input wire        i_mclk,
   input wire        i_rst,
   // stream and memories
   input wire        o_instr_ready,
   input wire [11:0] i_tbl_addr,
   input wire [15:0] i_dmem_rdata,
   input wire        o_dmem_we,
   input wire [15:0] o_dmem_wdata,
   input wire [11:0] o_pmem_addr,
   input wire        o_pmem_re,
   input wire [15:0] i_pmem_rdata,
   input wire        o_pmem_we,
   input wire [15:0] o_pmem_wdata,
   // port bus
   input wire        o_port_re,
   input wire        o_port_we,
   input wire [15:0] o_port_wdata,
   input wire [15:0] i_port_rdata,
   // results
   input wire        o_acc_we,
   input wire [15:0] o_mult,
   input wire [31:0] o_prod,
   input wire [15:0] o_status,
   input wire        o_int_off,
   input wire        o_sat_on
);
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (i_rst);

   ////////////////////////////////////////////////////////////////
   // table read: program word lands in data ram one cycle later
   sequence s_tbl_land;
      o_dmem_we && o_dmem_wdata == i_pmem_rdata;
   endsequence
   // the rest of a three-cycle table op issues no further strobe
   sequence s_tbl_quiet;
      (!o_pmem_re && !o_pmem_we) [*2];
   endsequence

   a_port_in_write: assert property (o_port_re |-> o_dmem_we && o_dmem_wdata == i_port_rdata)
      else $error("port input word not written to data ram");
   a_port_out_data: assert property (o_port_we |-> o_port_wdata == i_dmem_rdata && !o_dmem_we)
      else $error("port output word differs from data ram");
   a_port_op_spacing: assert property ((o_port_re || o_port_we) |=> !(o_port_re || o_port_we))
      else $error("port strobes closer than two cycles");
   a_tbl_read_land: assert property (o_pmem_re |=> s_tbl_land)
      else $error("table read word not written to data ram");
   a_tbl_op_spacing: assert property (o_pmem_re |=> s_tbl_quiet)
      else $error("table op overlapped by another");
   a_tbl_write_data: assert property (o_pmem_we |-> o_pmem_wdata == i_dmem_rdata && o_pmem_addr == i_tbl_addr)
      else $error("table write word or address wrong");
   a_status_flag_map: assert property (o_int_off == o_status[2] && o_sat_on == o_status[1])
      else $error("status flag outputs disagree with status word");
   a_reset_state: assert property (disable iff (1'b0) $fell(i_rst) |-> o_status == 16'h0004 && o_mult == 16'h0000 && o_prod == 32'h0 && o_instr_ready && !o_acc_we)
      else $error("state after reset wrong");
endmodule // mpd_core_checker

bind mpd_core mpd_core_checker #(.FIFO_DEPTH(FIFO_DEPTH), .FIFO_AW(FIFO_AW)) u_chk (
   .i_mclk, .i_rst, .o_instr_ready, .i_tbl_addr, .i_dmem_rdata, .o_dmem_we, .o_dmem_wdata,
   .o_pmem_addr, .o_pmem_re, .i_pmem_rdata, .o_pmem_we, .o_pmem_wdata, .o_port_re,
   .o_port_we, .o_port_wdata, .i_port_rdata, .o_acc_we, .o_mult, .o_prod, .o_status,
   .o_int_off, .o_sat_on);

// ### sim/mpd_mem_model.sv
// data ram, program space and port bus facing the decode block
`timescale 1ns/1ps
module mpd_mem_model (
   // clock
   input  wire        i_mclk,
   // data ram
   input  wire [7:0]  o_dmem_addr,
   output wire [15:0] i_dmem_rdata,
   input  wire        o_dmem_we,
   input  wire [7:0]  o_dmem_waddr,
   input  wire [15:0] o_dmem_wdata,
   // program space
   input  wire [11:0] o_pmem_addr,
   input  wire        o_pmem_re,
   output reg  [15:0] i_pmem_rdata,
   input  wire        o_pmem_we,
   input  wire [15:0] o_pmem_wdata,
   // port bus
   input  wire [2:0]  o_port_addr,
   input  wire        o_port_re,
   input  wire        o_port_we,
   input  wire [15:0] o_port_wdata,
   output wire [15:0] i_port_rdata
);
   reg [15:0] dmem     [0:255];   // data ram
   reg [15:0] pmem     [0:4095];  // program space
   reg [15:0] port_log [0:7];     // last word written to each port
   reg [15:0] port_last = 16'h0;  // last word this model drove

   // ram read is combinational
   assign i_dmem_rdata = dmem[o_dmem_addr];
   // unselected bus shows the inverse so a stale value never passes
   assign i_port_rdata = o_port_re ? 16'h1230 + {13'h0, o_port_addr} : ~port_last;

   initial i_pmem_rdata = 16'h0;

   ////////////////////////////////////////////////////////////////
   // writes land at the edge; program word answers a cycle after re
   always @(posedge i_mclk)
   begin
      if (o_dmem_we === 1'b1) dmem[o_dmem_waddr] <= o_dmem_wdata;
      if (o_pmem_we === 1'b1) pmem[o_pmem_addr] <= o_pmem_wdata;
      if (o_port_we === 1'b1) port_log[o_port_addr] <= o_port_wdata;
      if (o_port_re === 1'b1) port_last <= i_port_rdata;
      // toggles between reads, so the word is only good the cycle after
      i_pmem_rdata <= (o_pmem_re === 1'b1) ? pmem[o_pmem_addr] : ~i_pmem_rdata;
   end
endmodule // mpd_mem_model

// ### sim/dsp_multiply_control_io_decode_tb.sv
// self-checking bench for the multiply, control and i/o decode block
`timescale 1ns/1ps
`include "mpd_defines.vh"
module dsp_multiply_control_io_decode_tb;
   reg         i_mclk = 1'b0;
   reg         i_rst = 1'b1;
   reg         i_instr_valid = 1'b0;
   reg  [15:0] i_instr = 16'h0000;
   reg  [31:0] i_acc = 32'h0;
   reg  [7:0]  i_aux0 = 8'h20;    // indirect pointer 0
   reg  [7:0]  i_aux1 = 8'h70;    // indirect pointer 1
   reg         i_data_page = 1'b0;
   reg  [11:0] i_tbl_addr = 12'h123;
   wire        o_instr_ready, o_dmem_we, o_pmem_re, o_pmem_we, o_port_re, o_port_we;
   wire        o_acc_we, o_int_off, o_sat_on;
   wire [7:0]  o_dmem_addr, o_dmem_waddr;
   wire [15:0] i_dmem_rdata, o_dmem_wdata, i_pmem_rdata, o_pmem_wdata;
   wire [15:0] o_port_wdata, i_port_rdata, o_mult, o_status;
   wire [11:0] o_pmem_addr, o_stack_top;
   wire [2:0]  o_port_addr;
   wire [31:0] o_acc_wdata, o_prod;
   integer     miscompares = 0;
   integer     check_count = 0;
   integer     rd_cnt = 0;        // table reads seen
   reg  [31:0] acc_seen;          // last accumulator write
   reg         full_seen = 1'b0;  // stream was refused once

   mpd_core uut (.i_mclk, .i_rst, .i_instr_valid, .o_instr_ready, .i_instr, .i_acc,
      .i_aux0, .i_aux1, .i_data_page, .i_tbl_addr, .o_dmem_addr, .i_dmem_rdata, .o_dmem_we,
      .o_dmem_waddr, .o_dmem_wdata, .o_pmem_addr, .o_pmem_re, .i_pmem_rdata, .o_pmem_we,
      .o_pmem_wdata, .o_port_addr, .o_port_re, .o_port_we, .o_port_wdata, .i_port_rdata,
      .o_acc_we, .o_acc_wdata, .o_mult, .o_prod, .o_status, .o_int_off, .o_sat_on,
      .o_stack_top);
   mpd_mem_model u_mem (.i_mclk, .o_dmem_addr, .i_dmem_rdata, .o_dmem_we, .o_dmem_waddr,
      .o_dmem_wdata, .o_pmem_addr, .o_pmem_re, .i_pmem_rdata, .o_pmem_we, .o_pmem_wdata,
      .o_port_addr, .o_port_re, .o_port_we, .o_port_wdata, .i_port_rdata);

   always #2 i_mclk = ~i_mclk;

   // record accumulator writes and table reads
   always @(posedge i_mclk)
   begin
      if (o_acc_we === 1'b1) acc_seen <= o_acc_wdata;
      if (o_pmem_re === 1'b1) rd_cnt <= rd_cnt + 1;
   end

   ////////////////////////////////////////////////////////////////
   task check(input [31:0] seen, input [31:0] exp);
   begin
      check_count = check_count + 1;
      if (seen !== exp)
      begin
         miscompares = miscompares + 1;
         $display("CHECK FAILED at %0t: saw %h wanted %h", $time, seen, exp);
      end
   end
   endtask

   task conclude;
   begin
      $display("miscompares %0d of %0d checks", miscompares, check_count);
      if (miscompares == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   end
   endtask

   // offer a word and hold it until the edge that takes it
   task send(input [15:0] w);
      integer n;
   begin
      n = 0;
      @(negedge i_mclk);
      i_instr_valid = 1'b1;
      i_instr = w;
      while (o_instr_ready !== 1'b1 && n < 200)
      begin
         full_seen = 1'b1;
         @(negedge i_mclk);
         n = n + 1;
      end
      if (n == 200) check(1, 0);
      if (n == 200) conclude;
      @(posedge i_mclk);
   end
   endtask

   // one op then idle; eight cycles cover the longest op plus the fifo
   task run(input [15:0] w);
   begin
      send(w);
      @(negedge i_mclk);
      i_instr_valid = 1'b0;
      repeat (8) @(negedge i_mclk);
   end
   endtask

   ////////////////////////////////////////////////////////////////
   task t_reset;
   begin
      check(o_status, 16'h0004);
      check({o_int_off, o_sat_on, o_instr_ready}, 3'b101);
      check(o_prod, 0);
   end
   endtask

   task t_multiply;
   begin
      u_mem.dmem[8'h10] = 16'h0003;
      u_mem.dmem[8'h11] = 16'h0005;
      i_acc = 32'd100;
      run({`MPD_OP_LOAD_MULT, 8'h10});
      check(o_mult, 3);
      run({`MPD_OP_MULT_MEM, 8'h11});
      check(o_prod, 15);
      run({`MPD_OP_GROUP_7F, `MPD_LO_PROD_TO_ACC});
      check(acc_seen, 15);
      run({`MPD_OP_GROUP_7F, `MPD_LO_ADD_PROD});
      check(acc_seen, 115);
      run({`MPD_OP_GROUP_7F, `MPD_LO_SUB_PROD});
      check(acc_seen, 85);
      i_acc = 32'd200;
      run({`MPD_OP_LOAD_MULT_ACC, 8'h11});
      check(o_mult, 5);
      check(acc_seen, 215);
      u_mem.dmem[8'h20] = 16'h0007;
      i_acc = 32'd300;
      run({`MPD_OP_LOAD_ACC_MOVE, 8'h80});
      check({o_mult, u_mem.dmem[8'h21]}, {16'd7, 16'd7});
      check(acc_seen, 315);
      run({`MPD_PFX_MULT_CONST, 13'h0009});
      check(o_prod, 63);
      i_data_page = 1'b1;
      u_mem.dmem[8'h85] = 16'h5a5a;
      run({`MPD_OP_SHIFT_UP, 8'h05});
      check(u_mem.dmem[8'h86], 16'h5a5a);
      i_data_page = 1'b0;
   end
   endtask

   task t_status;
   begin
      run({`MPD_OP_GROUP_7F, `MPD_LO_SAT_ON});
      run({`MPD_OP_GROUP_7F, `MPD_LO_INT_ENABLE});
      check({o_sat_on, o_int_off}, 2'b10);
      run({`MPD_OP_STATUS_SAVE, 8'h30});
      check(u_mem.dmem[8'h30], 16'h0002);
      run({`MPD_OP_GROUP_7F, `MPD_LO_SAT_OFF});
      run({`MPD_OP_GROUP_7F, `MPD_LO_INT_DISABLE});
      check({o_sat_on, o_int_off}, 2'b01);
      u_mem.dmem[8'h31] = 16'hfff9;
      run({`MPD_OP_STATUS_RESTORE, 8'h31});
      check(o_status, 16'h0001);
      u_mem.dmem[8'h70] = 16'h0011;
      run({`MPD_OP_LOAD_MULT, 8'h80});
      check(o_mult, 16'h0011);
   end
   endtask

   task t_stack;
   begin
      i_acc = 32'h00000abc;
      run({`MPD_OP_GROUP_7F, `MPD_LO_PUSH});
      i_acc = 32'h00000123;
      run({`MPD_OP_GROUP_7F, `MPD_LO_PUSH});
      check(o_stack_top, 12'h123);
      run({`MPD_OP_GROUP_7F, `MPD_LO_POP});
      check(acc_seen, 32'h123);
      run({`MPD_OP_GROUP_7F, `MPD_LO_POP});
      check(acc_seen, 32'habc);
   end
   endtask

   // every port number, out then in
   task t_ports;
      integer p;
   begin
      for (p = 0; p < 8; p = p + 1)
      begin
         u_mem.dmem[8'h40 + p] = 16'hc000 + p;
         run({`MPD_PFX_PORT_OUT, p[2:0], 1'b0, 7'h40 + p[6:0]});
         check(u_mem.port_log[p], 16'hc000 + p);
         run({`MPD_PFX_PORT_IN, p[2:0], 1'b0, 7'h50 + p[6:0]});
         check(u_mem.dmem[8'h50 + p], 16'h1230 + p);
      end
   end
   endtask

   task t_table;
   begin
      u_mem.pmem[12'h123] = 16'hbeef;
      run({`MPD_OP_PROG_TO_DATA, 8'h60});
      check(u_mem.dmem[8'h60], 16'hbeef);
      u_mem.dmem[8'h61] = 16'h1357;
      i_tbl_addr = 12'h200;
      run({`MPD_OP_DATA_TO_PROG, 8'h61});
      check(u_mem.pmem[12'h200], 16'h1357);
      i_tbl_addr = 12'h123;
   end
   endtask

   // table reads offered every cycle outrun the decoder and fill the fifo
   task t_fill;
      integer i;
      integer c0;
   begin
      c0 = rd_cnt;
      for (i = 0; i < 64; i = i + 1) send({`MPD_OP_PROG_TO_DATA, 8'h62});
      run({`MPD_OP_GROUP_7F, `MPD_LO_NOP});
      repeat (250) @(negedge i_mclk);
      check(full_seen, 1);
      check(rd_cnt - c0, 64);
      check({o_instr_ready, u_mem.dmem[8'h62]}, {1'b1, 16'hbeef});
   end
   endtask

   initial
   begin
      repeat (5) @(negedge i_mclk);
      i_rst = 1'b0;
      t_reset;
      t_multiply;
      t_status;
      t_stack;
      t_ports;
      t_table;
      t_fill;
      conclude;
   end
endmodule // dsp_multiply_control_io_decode_tb
